// ### core/ruc_core.sv
`timescale 1ns/1ns
// Function
// - fabric reaches registers through shift register
// - only factory image may write update register
// - status records cause, captured into shift
// - control/status on oscillator, shift/update on link
// - control word bit layout as defined
// - image flag cleared on fall-back
// - application flag: read only, watchdog per enable bit
// - control fields zero at reset, fall-back
// - watchdog load is timeout over 17 zeros
// - five cause bits in status register
// - status zero after power-on reset
// - request low copies update, loads application
// - application load error falls back, records cause
// - running application triggers fall-back with cause
// - factory reads update, application reads control
// - watchdog off in factory, per enable otherwise
// - watchdog counts down from loaded value
// - watchdog starts once application reaches user mode
// - expiry sets timeout cause, reloads factory
// - power-up loads factory from page zero
module ruc_core (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic upgrade_shift_clock,
    input wire logic shift_or_load_select,
    input wire logic capture_or_update_select,
    input wire logic upgrade_serial_in,
    output logic upgrade_serial_out,
    input wire logic fabric_reconfig_request_n,
    input wire logic timer_kick_n,
    input wire logic external_reconfig_n,
    input wire logic config_status_n,
    input wire logic crc_error,
    input wire logic config_done,
    output logic load_request,
    output logic [ruc_pkg::PAGE_W-1:0] load_start_page,
    output logic image_is_application,
    output logic timer_running,
    output logic [ruc_pkg::STAT_W-1:0] cause_status
);

    // ****************************************************************
    // oscillator domain: input synchronisers
    // ****************************************************************
    // six pins cross from outside the oscillator domain
    localparam int NSYNC = 6;

    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] pin_s1;
    logic [NSYNC-1:0] pin_s2;
    logic [NSYNC-1:0] pin_s3;

    // pins packed for one synchroniser bank
    assign pin_raw = {config_done, crc_error, config_status_n, external_reconfig_n,
                      timer_kick_n, fabric_reconfig_request_n};

    // two flops per pin, third stage only for edge detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // idle levels: request pins high, flags low, so no false edge
            pin_s1 <= 6'h0f;
            pin_s2 <= 6'h0f;
            pin_s3 <= 6'h0f;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // edge and level detectors on the synchronised pins
    logic fab_req_fall;
    logic kick_low;
    logic ext_req_fall;
    logic config_status_n_low;
    logic crc_seen;
    logic done_seen;

    assign fab_req_fall = pin_s3[0] & ~pin_s2[0];
    assign kick_low = ~pin_s2[1];
    assign ext_req_fall = pin_s3[2] & ~pin_s2[2];
    assign config_status_n_low = ~pin_s2[3];
    assign crc_seen = pin_s2[4];
    assign done_seen = pin_s2[5] & ~pin_s3[5];

    // ****************************************************************
    // oscillator domain: update register shadow
    // ****************************************************************
    logic [ruc_pkg::CTRL_W-1:0] update_reg;
    logic upd_tgl;
    logic [2:0] upd_sync;
    logic [ruc_pkg::CTRL_W-1:0] update_shadow;
    logic clr_tgl;
    logic fallback;

    // update word is stable when its toggle arrives
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            upd_sync <= 3'h0;
        end else begin
            upd_sync <= {upd_sync[1:0], upd_tgl};
        end
    end

    // shadow follows the update word, a fall-back clears it
    always_ff @(posedge clk_sys) begin
        if (rst || fallback) begin
            update_shadow <= ruc_pkg::CTRL_RESET;
        end else if (upd_sync[2] != upd_sync[1]) begin
            update_shadow <= update_reg;
        end
    end

    // ****************************************************************
    // oscillator domain: sequencer, control and status
    // ****************************************************************
    ruc_pkg::ruc_state_t state;
    logic [ruc_pkg::CTRL_W-1:0] ctrl;
    logic [ruc_pkg::STAT_W-1:0] status;
    logic [ruc_pkg::STAT_W-1:0] next_cause;
    logic wd_expired;

    // one-hot cause word for a status bit position
    function automatic logic [ruc_pkg::STAT_W-1:0] cause_of(input int pos);
        logic [ruc_pkg::STAT_W-1:0] word;
        word = ruc_pkg::STAT_RESET;
        word[pos] = 1'b1;
        return word;
    endfunction

    // cause of a trigger in the application image, one bit set
    always_comb begin
        next_cause = ruc_pkg::STAT_RESET;
        if (crc_seen) begin
            next_cause = cause_of(ruc_pkg::ST_CRC);
        end else if (config_status_n_low) begin
            next_cause = cause_of(ruc_pkg::ST_CONFIG_STATUS_N);
        end else if (ext_req_fall) begin
            next_cause = cause_of(ruc_pkg::ST_EXTERNAL);
        end else if (fab_req_fall && state == ruc_pkg::ST_RUN_APP) begin
            next_cause = cause_of(ruc_pkg::ST_FABRIC);
        end else if (wd_expired && state == ruc_pkg::ST_RUN_APP) begin
            next_cause = cause_of(ruc_pkg::ST_TIMEOUT);
        end
    end

    // fall-back only out of an application load or run
    assign fallback = (state == ruc_pkg::ST_LOAD_APP || state == ruc_pkg::ST_RUN_APP) && (next_cause != '0);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ruc_pkg::ST_LOAD_FACTORY;
            ctrl <= ruc_pkg::CTRL_RESET;
            status <= ruc_pkg::STAT_RESET;
            load_request <= 1'b1;
            load_start_page <= ruc_pkg::FACTORY_PAGE;
            clr_tgl <= 1'b0;
        end else begin
            load_request <= 1'b0;
            if (fallback) begin
                // clear control, clear update, record cause, reload factory
                ctrl <= ruc_pkg::CTRL_RESET;
                status <= next_cause;
                clr_tgl <= ~clr_tgl;
                load_request <= 1'b1;
                load_start_page <= ruc_pkg::FACTORY_PAGE;
                state <= ruc_pkg::ST_LOAD_FACTORY;
            end else begin
                unique case (state)
                    ruc_pkg::ST_LOAD_FACTORY: begin
                        if (done_seen) begin
                            state <= ruc_pkg::ST_RUN_FACTORY;
                        end
                    end
                    ruc_pkg::ST_RUN_FACTORY: begin
                        if (ext_req_fall) begin
                            status <= cause_of(ruc_pkg::ST_EXTERNAL);
                            load_request <= 1'b1;
                            load_start_page <= ruc_pkg::FACTORY_PAGE;
                            state <= ruc_pkg::ST_LOAD_FACTORY;
                        end else if (fab_req_fall) begin
                            // update word becomes control, load its image
                            ctrl <= update_shadow;
                            status <= cause_of(ruc_pkg::ST_FABRIC);
                            load_request <= 1'b1;
                            load_start_page <= update_shadow[ruc_pkg::PAGE_LSB +: ruc_pkg::PAGE_W];
                            state <= ruc_pkg::ST_LOAD_APP;
                        end
                    end
                    ruc_pkg::ST_LOAD_APP: begin
                        if (done_seen) begin
                            state <= ruc_pkg::ST_RUN_APP;
                        end
                    end
                    ruc_pkg::ST_RUN_APP: begin
                        state <= ruc_pkg::ST_RUN_APP;
                    end
                endcase
            end
        end
    end

    // flag and status outputs
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            image_is_application <= 1'b0;
            cause_status <= ruc_pkg::STAT_RESET;
        end else begin
            image_is_application <= ctrl[ruc_pkg::ANF_BIT];
            cause_status <= status;
        end
    end

    // ****************************************************************
    // oscillator domain: user watchdog
    // ****************************************************************
    // watchdog runs only with image flag and enable both set
    logic [ruc_pkg::WD_W-1:0] wd_count;
    logic wd_enable;
    logic [ruc_pkg::WD_W-1:0] wd_load;

    assign wd_enable = ctrl[ruc_pkg::ANF_BIT] & ctrl[ruc_pkg::WDEN_BIT];
    assign wd_load = {ctrl[ruc_pkg::TMO_LSB +: ruc_pkg::TMO_W], ruc_pkg::WD_PAD_BITS};
    assign wd_expired = timer_running && (wd_count == ruc_pkg::WD_ZERO);

    // counts down from the loaded value in user mode; a kick reloads
    always_ff @(posedge clk_sys) begin
        if (rst || fallback) begin
            wd_count <= ruc_pkg::WD_ZERO;
            timer_running <= 1'b0;
        end else if (state == ruc_pkg::ST_LOAD_APP && done_seen && wd_enable) begin
            wd_count <= wd_load;
            timer_running <= 1'b1;
        end else if (timer_running && kick_low) begin
            wd_count <= wd_load;
        end else if (timer_running && wd_count != ruc_pkg::WD_ZERO) begin
            wd_count <= wd_count - 29'h0000_0001;
        end
    end

    // ****************************************************************
    // oscillator domain: snapshot of control and status for the link
    // ****************************************************************
    logic [ruc_pkg::SHIFT_W-1:0] snap_word;
    logic snap_tgl;

    // word only changes on reconfiguration, held with a toggle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            snap_word <= ruc_pkg::SHIFT_RESET;
            snap_tgl <= 1'b0;
        end else if ({status, ctrl} != snap_word) begin
            snap_word <= {status, ctrl};
            snap_tgl <= ~snap_tgl;
        end
    end

    // ****************************************************************
    // link domain: reset, snapshot and clear crossings
    // ****************************************************************
    logic rst_l1;
    logic rst_l2;
    logic [2:0] snap_sync;
    logic [2:0] clr_sync;
    logic [ruc_pkg::SHIFT_W-1:0] link_view;

    // reset reaches the link side two link edges late
    always_ff @(posedge upgrade_shift_clock) begin
        rst_l1 <= rst;
        rst_l2 <= rst_l1;
    end

    // toggles pass two flops, the third flags their edge
    always_ff @(posedge upgrade_shift_clock) begin
        if (rst_l2) begin
            snap_sync <= 3'h0;
            clr_sync <= 3'h0;
        end else begin
            snap_sync <= {snap_sync[1:0], snap_tgl};
            clr_sync <= {clr_sync[1:0], clr_tgl};
        end
    end

    // copy the held snapshot once its toggle has arrived
    always_ff @(posedge upgrade_shift_clock) begin
        if (rst_l2) begin
            link_view <= ruc_pkg::SHIFT_RESET;
        end else if (snap_sync[2] != snap_sync[1]) begin
            link_view <= snap_word;
        end
    end

    // ****************************************************************
    // link domain: shift and update registers
    // ****************************************************************
    logic [ruc_pkg::SHIFT_W-1:0] shift_reg;
    logic link_anf;

    // image flag as the link side sees it
    assign link_anf = link_view[ruc_pkg::ANF_BIT];

    // shift lsb first; capture status above the data word
    always_ff @(posedge upgrade_shift_clock) begin
        if (rst_l2) begin
            shift_reg <= ruc_pkg::SHIFT_RESET;
        end else if (shift_or_load_select) begin
            shift_reg <= {upgrade_serial_in, shift_reg[ruc_pkg::SHIFT_W-1:1]};
        end else if (capture_or_update_select) begin
            if (link_anf) begin
                shift_reg <= link_view;
            end else begin
                shift_reg <= {link_view[ruc_pkg::SHIFT_W-1 -: ruc_pkg::STAT_W], update_reg};
            end
        end
    end

    // update only from the factory image; a fall-back clears it
    // a clear leaves the toggle alone, so no false update crosses
    always_ff @(posedge upgrade_shift_clock) begin
        if (rst_l2) begin
            update_reg <= ruc_pkg::CTRL_RESET;
            upd_tgl <= 1'b0;
        end else if (clr_sync[2] != clr_sync[1]) begin
            update_reg <= ruc_pkg::CTRL_RESET;
        end else if (!shift_or_load_select && !capture_or_update_select && !link_anf) begin
            update_reg <= shift_reg[ruc_pkg::CTRL_W-1:0];
            upd_tgl <= ~upd_tgl;
        end
    end

    // registered copy of the bit now at the low end
    always_ff @(posedge upgrade_shift_clock) begin
        if (rst_l2) begin
            upgrade_serial_out <= 1'b0;
        end else begin
            upgrade_serial_out <= shift_or_load_select ? shift_reg[1] : shift_reg[0];
        end
    end

endmodule

// ### inc/ruc_pkg.sv
// ****************************************************************
// remote upgrade controller constants
// ****************************************************************
package ruc_pkg;

    // control word layout
    localparam int CTRL_W = 38;
    localparam int ANF_BIT = 0;
    localparam int PAGE_LSB = 1;
    localparam int PAGE_W = 24;
    localparam int WDEN_BIT = 25;
    localparam int TMO_LSB = 26;
    localparam int TMO_W = 12;

    // watchdog load value: timeout bits over a zero pad
    localparam int WD_W = 29;
    localparam int WD_PAD = 17;

    // cause status layout
    localparam int STAT_W = 5;
    localparam int ST_CRC = 0;
    localparam int ST_CONFIG_STATUS_N = 1;
    localparam int ST_FABRIC = 2;
    localparam int ST_EXTERNAL = 3;
    localparam int ST_TIMEOUT = 4;

    // shift register holds status above the data word
    localparam int SHIFT_W = CTRL_W + STAT_W;

    // values after reset and after fall-back
    localparam logic [CTRL_W-1:0] CTRL_RESET = 38'h00_0000_0000;
    localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
    localparam logic [PAGE_W-1:0] FACTORY_PAGE = 24'h00_0000;
    localparam logic [WD_PAD-1:0] WD_PAD_BITS = 17'h0_0000;
    localparam logic [WD_W-1:0] WD_ZERO = 29'h0000_0000;
    localparam logic [SHIFT_W-1:0] SHIFT_RESET = 43'h000_0000_0000;

    // configuration sequencer states
    typedef enum logic [1:0] {
        ST_LOAD_FACTORY,
        ST_RUN_FACTORY,
        ST_LOAD_APP,
        ST_RUN_APP
    } ruc_state_t;

endpackage

// ### test/ruc_core_sva.sv
`timescale 1ns/1ns
// ************
// port checker
// ************
module ruc_core_chk (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load_request,
    input wire logic [ruc_pkg::PAGE_W-1:0] load_start_page,
    input wire logic image_is_application,
    input wire logic timer_running,
    input wire logic [ruc_pkg::STAT_W-1:0] cause_status
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // fall-back step: flag drops with a load
    sequence s_fall;
        $fell(image_is_application) ##0 $past(load_request);
    endsequence
    // load, cause and watchdog relations
    chk_load_pulse: assert property (load_request |=> !load_request)
        else $error("load request wider than one cycle");
    chk_factory_page: assert property (load_request ##1 !image_is_application |-> load_start_page == 24'h00_0000)
        else $error("factory load not from page zero");
    chk_fall_load: assert property ($fell(image_is_application) |-> $past(load_request))
        else $error("flag cleared without a factory load");
    chk_fall_cause: assert property (s_fall |=> cause_status != 5'h00)
        else $error("fall-back left no cause");
    chk_app_load: assert property ($rose(image_is_application) |-> $past(load_request))
        else $error("application flag set without a load");
    chk_cause_one: assert property ($changed(cause_status) |-> $past(load_request) && $onehot0(cause_status))
        else $error("cause changed outside a reload");
    chk_timer_factory: assert property (!image_is_application ##1 !image_is_application |-> !timer_running)
        else $error("watchdog running in factory image");
    chk_timer_start: assert property ($rose(timer_running) |-> image_is_application && !load_request)
        else $error("watchdog started outside user mode");
    chk_status_reset: assert property (disable iff (1'b0) rst ##1 rst |=> cause_status == 5'h00)
        else $error("status not clear after reset");
    cover property (s_fall);
endmodule
bind ruc_core ruc_core_chk i_chk (
    .clk_sys(clk_sys), .rst(rst), .load_request(load_request), .load_start_page(load_start_page),
    .image_is_application(image_is_application), .timer_running(timer_running), .cause_status(cause_status));

// ### test/ruc_loader_model.sv
`timescale 1ns/1ns
// ************
// image loader
// ************
module ruc_loader_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load_request,
    input wire logic fail_next,
    input wire logic [3:0] delay,
    output logic config_done,
    output logic crc_error
);
    int cnt;
    // each load: wait, then user mode or a crc fault
    always_ff @(posedge clk_sys) begin
        if (rst || load_request) begin
            cnt <= int'(delay) + 2;
            config_done <= 1'b0;
            crc_error <= 1'b0;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                config_done <= !fail_next;
                crc_error <= fail_next;
            end
        end
    end
endmodule

// ### test/tb.sv
`timescale 1ns/1ns
// *****
// bench
// *****
module tb;
    logic clk_sys = 0, rst = 1, upgrade_shift_clock = 0, upgrade_serial_in = 0, fail_next = 0;
    logic shift_or_load_select = 0, capture_or_update_select = 1, timer_kick_n = 1;
    logic fabric_reconfig_request_n = 1, external_reconfig_n = 1, config_status_n = 1;
    logic crc_error, config_done, load_request, image_is_application, timer_running, upgrade_serial_out;
    logic [ruc_pkg::PAGE_W-1:0] load_start_page, page;
    logic [ruc_pkg::STAT_W-1:0] cause_status, m_stat;
    logic [3:0] delay = 4'h3;
    logic [ruc_pkg::CTRL_W-1:0] m_upd, m_ctrl, w;
    logic [ruc_pkg::SHIFT_W-1:0] rd;
    int err_total = 0, n_compared = 0, seed = 69, cyc = 0;
    logic [4:0] cause_tab [3] = '{5'h01, 5'h02, 5'h10};
    ruc_core i_dut (
        .clk_sys(clk_sys), .rst(rst), .upgrade_shift_clock(upgrade_shift_clock),
        .shift_or_load_select(shift_or_load_select), .capture_or_update_select(capture_or_update_select),
        .upgrade_serial_in(upgrade_serial_in), .upgrade_serial_out(upgrade_serial_out),
        .fabric_reconfig_request_n(fabric_reconfig_request_n), .timer_kick_n(timer_kick_n),
        .external_reconfig_n(external_reconfig_n), .config_status_n(config_status_n),
        .crc_error(crc_error), .config_done(config_done), .load_request(load_request),
        .load_start_page(load_start_page), .image_is_application(image_is_application),
        .timer_running(timer_running), .cause_status(cause_status));
    ruc_loader_model i_load (
        .clk_sys(clk_sys), .rst(rst), .load_request(load_request), .fail_next(fail_next), .delay(delay),
        .config_done(config_done), .crc_error(crc_error));
    // clocks, link clock unrelated in phase
    initial forever #25 clk_sys = ~clk_sys;
    initial begin
        #17;
        forever #40 upgrade_shift_clock = ~upgrade_shift_clock;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            $display("CHECK FAILED %0t timeout", $time);
            complete_run();
        end
    end
    task automatic complete_run();
        if (err_total == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic cmp_read(input logic [42:0] exp);
        n_compared++;
        if (rd !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t read %h exp %h", $time, rd, exp);
        end
    endtask
    task automatic cmp_pin(input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t pin %h exp %h", $time, got, exp);
        end
    endtask
    // capture then shift out, bit 0 first
    task automatic link_read();
        repeat (2) @(posedge upgrade_shift_clock);
        shift_or_load_select <= 1'b1;
        for (int i = 0; i < ruc_pkg::SHIFT_W; i++) begin
            @(negedge upgrade_shift_clock);
            rd[i] = upgrade_serial_out;
            @(posedge upgrade_shift_clock);
        end
        shift_or_load_select <= 1'b0;
        cmp_read({m_stat, m_ctrl[0] ? m_ctrl : m_upd});
    endtask
    // shift a word in, then update
    task automatic link_write(input logic [37:0] word);
        @(posedge upgrade_shift_clock);
        shift_or_load_select <= 1'b1;
        for (int i = 0; i < ruc_pkg::SHIFT_W; i++) begin
            upgrade_serial_in <= (i < 38) ? word[i] : 1'b0;
            @(posedge upgrade_shift_clock);
        end
        shift_or_load_select <= 1'b0;
        capture_or_update_select <= 1'b0;
        @(posedge upgrade_shift_clock);
        capture_or_update_select <= 1'b1;
        if (!m_ctrl[0]) m_upd = word;
    endtask
    // wait for a load, then user mode or fault
    task automatic wait_load(input logic [23:0] exp);
        int t;
        for (t = 0; t < 200 && load_request !== 1'b1; t++) @(negedge clk_sys);
        cmp_pin({23'h0, load_request}, 24'h1);
        cmp_pin(load_start_page, exp);
        fabric_reconfig_request_n <= 1'b1;
        external_reconfig_n <= 1'b1;
        delay <= 4'($random(seed));
        // flags of the previous load drop one cycle after the request
        repeat (2) @(negedge clk_sys);
        for (t = 0; t < 200 && config_done !== 1'b1 && crc_error !== 1'b1; t++) @(negedge clk_sys);
        cmp_pin({23'h0, config_done | crc_error}, 24'h1);
    endtask
    task automatic settle_check();
        repeat (8) @(negedge clk_sys);
        cmp_pin({23'h0, image_is_application}, {23'h0, m_ctrl[0]});
        cmp_pin({19'h0, cause_status}, {19'h0, m_stat});
        link_read();
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        m_upd = '0;
        m_ctrl = '0;
        m_stat = 5'h00;
        repeat (30) @(posedge clk_sys);
        settle_check();
        page = 24'($random(seed));
        w = {12'h001, 1'b1, page, 1'b1};
        link_write(w);
        link_read();
        repeat (10) @(posedge clk_sys);
        fabric_reconfig_request_n <= 1'b0;
        wait_load(page);
        m_ctrl = m_upd;
        m_stat = 5'h04;
        settle_check();
        cmp_pin({23'h0, timer_running}, 24'h1);
        link_write(~w);
        link_read();
        timer_kick_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        timer_kick_n <= 1'b1;
        external_reconfig_n <= 1'b0;
        wait_load(24'h0);
        m_ctrl = '0;
        m_upd = '0;
        m_stat = 5'h08;
        settle_check();
        // crc in load, status pin as the load completes, watchdog expiry
        for (int c = 0; c < 3; c++) begin
            page = 24'($random(seed));
            link_write({12'h000, c == 2, page, 1'b1});
            repeat (10) @(posedge clk_sys);
            fail_next <= (c == 0);
            fabric_reconfig_request_n <= 1'b0;
            wait_load(page);
            fail_next <= 1'b0;
            config_status_n <= (c != 1);
            wait_load(24'h0);
            config_status_n <= 1'b1;
            m_ctrl = '0;
            m_upd = '0;
            m_stat = cause_tab[c];
            settle_check();
        end
        complete_run();
    end
endmodule
